// >>> rtl/pvia_top.v
// process value integrator and zero/span adjust with axi4-lite registers
// Summary of operation
// - minute base: one integration step each 60 ms, 32-bit total.
// - each step adds process value over 1000, so 1000 per unit.
// - hour base: step every 3.6 s, 1000 gives 500/1000/2000 totals.
// - total is signed 32 bit; overflow leaves result undefined.
// - 32768 on minute base loses 47185920 daily, valid to day 45.
// - adjusted = (in - rmin) * gain/10000 + rmin + zero offset.
// - zero is pure offset, gain multiplies; for inputs and outputs.
// - shorted cold junction terminals stop cold junction compensation.
// - hour base step is 3.6 s, total held in one 32-bit register.
`timescale 1ns/10ps
`include "pvia_defines.vh"
module pvia_top #(
   parameter [31:0] MIN_CYC = `PVIA_MIN_STEP_CYC,
   parameter [31:0] HOUR_CYC = `PVIA_HOUR_STEP_CYC
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire cj_short,
   output reg cj_comp_en
);
   reg [3:0] ctrl_q;
   reg [15:0] pv_q, zero_q, gain_q, rmin_q, raw_q;
   reg [31:0] total_q;
   reg [15:0] rem_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg aw_have_q, w_have_q;
   reg [2:0] cj_sync_q;
   reg cj_state_q;
   wire step;
   wire [31:0] adj;

   function [15:0] merge16;
      input [15:0] old;
      input [31:0] d;
      input [3:0] s;
      begin
         merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
      end
   endfunction

   function known;
      input [7:0] a;
      begin
         known = (a[1:0] == 2'b00) && (a <= `PVIA_REG_REM);
      end
   endfunction

   pvia_step_timer #(.MIN_CYC(MIN_CYC), .HOUR_CYC(HOUR_CYC)) u_tmr (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(ctrl_q[`PVIA_CTRL_START] & ~ctrl_q[`PVIA_CTRL_CLEAR]),
      .hour_sel(ctrl_q[`PVIA_CTRL_HOUR]),
      .step(step)
   );

   pvia_adjust u_adj (
      .aclk(aclk),
      .aresetn(aresetn),
      .raw(raw_q),
      .rmin(rmin_q),
      .zero(zero_q),
      .gain(gain_q),
      .adj(adj)
   );

   // fractional remainder kept so pv/1000 per step is exact over time
   wire signed [17:0] acc = $signed({{2{rem_q[15]}}, rem_q}) +
      $signed({{2{pv_q[15]}}, pv_q});
   wire signed [17:0] whole = acc / 18'sd1000;
   wire signed [17:0] frac = acc - whole * 18'sd1000;

   wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         ctrl_q <= 4'h0;
         pv_q <= 16'h0;
         zero_q <= 16'h0;
         gain_q <= `PVIA_GAIN_RST;
         rmin_q <= 16'h0;
         raw_q <= 16'h0;
         total_q <= 32'h0;
         rem_q <= 16'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         // integration; a software clear below overrides this step
         if (ctrl_q[`PVIA_CTRL_CLEAR]) begin
            total_q <= 32'h0;
            rem_q <= 16'h0;
         end else if (step && ctrl_q[`PVIA_CTRL_START]) begin
            // wraps on overflow, result then undefined by contract
            total_q <= total_q + {{14{whole[17]}}, whole};
            rem_q <= frac[15:0];
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known(awaddr_q) ? 2'b00 : 2'b10;
            case (awaddr_q)
               `PVIA_REG_CTRL: begin
                  if (wstrb_q[0])
                     ctrl_q <= wdata_q[3:0];
               end
               `PVIA_REG_PV: pv_q <= merge16(pv_q, wdata_q, wstrb_q);
               `PVIA_REG_ZERO: zero_q <= merge16(zero_q, wdata_q, wstrb_q);
               `PVIA_REG_GAIN: gain_q <= merge16(gain_q, wdata_q, wstrb_q);
               `PVIA_REG_RMIN: rmin_q <= merge16(rmin_q, wdata_q, wstrb_q);
               `PVIA_REG_RAW: raw_q <= merge16(raw_q, wdata_q, wstrb_q);
               default: begin
               end
            endcase
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= known(s_axi_araddr) ? 2'b00 : 2'b10;
         case (s_axi_araddr)
            `PVIA_REG_CTRL: s_axi_rdata <= {27'h0, cj_state_q, ctrl_q};
            `PVIA_REG_PV: s_axi_rdata <= {16'h0, pv_q};
            `PVIA_REG_TOTAL: s_axi_rdata <= total_q;
            `PVIA_REG_ZERO: s_axi_rdata <= {16'h0, zero_q};
            `PVIA_REG_GAIN: s_axi_rdata <= {16'h0, gain_q};
            `PVIA_REG_RMIN: s_axi_rdata <= {16'h0, rmin_q};
            `PVIA_REG_RAW: s_axi_rdata <= {16'h0, raw_q};
            `PVIA_REG_ADJ: s_axi_rdata <= adj;
            `PVIA_REG_REM: s_axi_rdata <= {16'h0, rem_q};
            default: s_axi_rdata <= 32'h0;
         endcase
      end
   end

   // cold junction short pin: three stages, change once stages 2 and 3 agree
   always @(posedge aclk) begin
      if (!aresetn) begin
         cj_sync_q <= 3'b000;
         cj_state_q <= 1'b0;
         cj_comp_en <= 1'b1;
      end else begin
         cj_sync_q <= {cj_sync_q[1:0], cj_short};
         if (cj_sync_q[2] == cj_sync_q[1])
            cj_state_q <= cj_sync_q[1];
         // software may also force compensation off for calibration
         cj_comp_en <= ~(cj_state_q | ctrl_q[`PVIA_CTRL_CJOFF]);
      end
   end
endmodule

// >>> rtl/pvia_defines.vh
// constants for the process value integrator and adjust block
`ifndef PVIA_DEFINES_VH
`define PVIA_DEFINES_VH
`define PVIA_CLK_HZ 200000000
`define PVIA_MIN_STEP_MS 60
`define PVIA_HOUR_STEP_MS 3600
`define PVIA_MIN_STEP_CYC (`PVIA_CLK_HZ / 1000 * `PVIA_MIN_STEP_MS)
`define PVIA_HOUR_STEP_CYC (`PVIA_CLK_HZ / 1000 * `PVIA_HOUR_STEP_MS)
`define PVIA_STEP_DIV 1000
`define PVIA_GAIN_DIV 10000
`define PVIA_GAIN_RST 16'h2710
`define PVIA_REG_CTRL 8'h00
`define PVIA_REG_PV 8'h04
`define PVIA_REG_TOTAL 8'h08
`define PVIA_REG_ZERO 8'h0c
`define PVIA_REG_GAIN 8'h10
`define PVIA_REG_RMIN 8'h14
`define PVIA_REG_RAW 8'h18
`define PVIA_REG_ADJ 8'h1c
`define PVIA_REG_REM 8'h20
`define PVIA_CTRL_START 0
`define PVIA_CTRL_CLEAR 1
`define PVIA_CTRL_HOUR 2
`define PVIA_CTRL_CJOFF 3
`endif

// >>> rtl/pvia_step_timer.v
// step pulse divider for minute or hour time base
`timescale 1ns/10ps
`include "pvia_defines.vh"
module pvia_step_timer #(
   parameter [31:0] MIN_CYC = `PVIA_MIN_STEP_CYC,
   parameter [31:0] HOUR_CYC = `PVIA_HOUR_STEP_CYC
) (
   input wire aclk,
   input wire aresetn,
   input wire run,
   input wire hour_sel,
   output reg step
);
   reg [31:0] cnt_q;
   wire [31:0] lim = hour_sel ? HOUR_CYC : MIN_CYC;
   always @(posedge aclk) begin
      if (!aresetn || !run) begin
         cnt_q <= 32'h0;
         step <= 1'b0;
      end else if (cnt_q >= lim - 32'h1) begin
         cnt_q <= 32'h0;
         step <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h1;
         step <= 1'b0;
      end
   end
endmodule

// >>> rtl/pvia_adjust.v
// zero offset and span gain correction, registered
`timescale 1ns/10ps
module pvia_adjust (
   input wire aclk,
   input wire aresetn,
   input wire [15:0] raw,
   input wire [15:0] rmin,
   input wire [15:0] zero,
   input wire [15:0] gain,
   output reg [31:0] adj
);
   wire signed [17:0] diff = $signed({raw[15], raw[15], raw}) -
      $signed({rmin[15], rmin[15], rmin});
   wire signed [35:0] prod = diff * $signed({2'b00, gain});
   // truncating division toward zero, gain in 0.0001 units
   wire signed [35:0] q = prod / $signed(36'd10000);
   wire signed [35:0] sum = q + $signed({{20{rmin[15]}}, rmin}) +
      $signed({{20{zero[15]}}, zero});
   always @(posedge aclk) begin
      if (!aresetn)
         adj <= 32'h0;
      else
         adj <= sum[31:0];
   end
endmodule

// >>> test/pvia_chk_assertions.sv
// handshake and cold junction checks on the top ports
`timescale 1ns/10ps
module pvia_chk (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire cj_short,
   input wire cj_comp_en
);
   default clocking dcb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wtake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_cj_held;
      cj_short [*6];
   endsequence
   a_reset_idle: assert property ($rose(aresetn) |-> s_axi_awready &&
      !s_axi_bvalid && !s_axi_rvalid && cj_comp_en) else $error("idle");
   a_wr_answer: assert property (s_wtake |-> ##[1:2] s_axi_bvalid)
      else $error("no b");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("b drop");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("no r");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("r drop");
   a_ar_pend: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("ar open");
   a_aw_pend: assert property (s_axi_bvalid |-> !s_axi_awready &&
      !s_axi_wready) else $error("aw open");
   a_cj_stop: assert property (s_cj_held |=> !cj_comp_en)
      else $error("cj on");
endmodule
bind pvia_top pvia_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .cj_short, .cj_comp_en);

// >>> test/pvia_cpu.sv
// controller cpu model: register bus master
`timescale 1ns/10ps
module pvia_cpu (
   input wire aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   output logic s_axi_rready
);
   // response code of the last completed write
   logic [1:0] last_bresp = 2'b00;
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
      {s_axi_arvalid, s_axi_rready} = 2'b00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
   end
   // released payload is inverted so a stale value never looks valid
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge aclk);
         {s_axi_awaddr, s_axi_wdata} <= {a, d};
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
         fork
            begin
               do @(posedge aclk); while (!s_axi_awready);
               {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            end
            begin
               do @(posedge aclk); while (!s_axi_wready);
               {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
            end
         join
         do @(posedge aclk); while (!s_axi_bvalid);
         last_bresp = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, output [31:0] d, output [1:0] r);
      begin
         @(posedge aclk);
         {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
         do @(posedge aclk); while (!s_axi_arready);
         {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
         do @(posedge aclk); while (!s_axi_rvalid);
         {d, r} = {s_axi_rdata, s_axi_rresp};
         s_axi_rready <= 1'b0;
      end
   endtask
endmodule

// >>> test/tb_process_value_integrator_adjust.sv
// bench: register scenarios through the cpu model
`timescale 1ns/10ps
`include "pvia_defines.vh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module tb_process_value_integrator_adjust;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic cj_short = 1'b0;
   wire [7:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0] s_axi_wstrb;
   wire [1:0] s_axi_rresp, s_axi_bresp;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   wire s_axi_rvalid, s_axi_rready, cj_comp_en;
   int fails = 0;
   int cmp_count = 0;
   logic [31:0] d, t;
   logic [1:0] r;
   pvia_top #(.MIN_CYC(32'd10), .HOUR_CYC(32'd20)) DUT (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cj_short, .cj_comp_en);
   pvia_cpu cpu (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", cmp_count, fails);
         if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // clear first, run n cycles, stop, then the total must hold still
   task integ(input [31:0] pv, input [31:0] c, input int n, lo, hi);
      begin
         cpu.wr(`PVIA_REG_CTRL, 32'h2);
         cpu.wr(`PVIA_REG_PV, pv);
         cpu.wr(`PVIA_REG_CTRL, c);
         repeat (n) @(posedge aclk);
         cpu.wr(`PVIA_REG_CTRL, c & 32'hfffffffe);
         cpu.rd(`PVIA_REG_TOTAL, t, r);
         `CHK("total", 1'b1, $signed(t) >= lo && $signed(t) <= hi)
         repeat (30) @(posedge aclk);
         cpu.rd(`PVIA_REG_TOTAL, d, r);
         `CHK("held", t, d)
      end
   endtask
   initial forever #2.5 aclk = ~aclk;
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      cpu.rd(`PVIA_REG_GAIN, d, r);
      `CHK("gain", 32'h00002710, d)
      `CHK("cj", 1'b1, cj_comp_en)
      cpu.wr(`PVIA_REG_RMIN, 32'h0);
      cpu.wr(`PVIA_REG_RAW, 32'd500);
      cpu.wr(`PVIA_REG_GAIN, 32'd10060);
      cpu.wr(`PVIA_REG_ZERO, 32'd5);
      cpu.rd(`PVIA_REG_ADJ, d, r);
      `CHK("adj", 32'd508, d)
      cpu.wr(`PVIA_REG_RMIN, 32'd100);
      cpu.rd(`PVIA_REG_ADJ, d, r);
      `CHK("adj", 32'd507, d)
      cpu.wr(`PVIA_REG_ZERO, 32'hfffffffb);
      cpu.rd(`PVIA_REG_ADJ, d, r);
      `CHK("adj", 32'd497, d)
      integ(32'd500, 32'h1, 100, 4, 6);
      integ(32'd1000, 32'h5, 200, 9, 11);
      integ(32'hffff8000, 32'h1, 100, -400, -250);
      cpu.wr(`PVIA_REG_CTRL, 32'h3);
      repeat (50) @(posedge aclk);
      cpu.rd(`PVIA_REG_TOTAL, d, r);
      `CHK("clear", 32'h0, d)
      cpu.rd(8'h40, d, r);
      `CHK("resp", 2'b10, r)
      `CHK("rdata", 32'h0, d)
      cpu.wr(8'h40, 32'h1);
      `CHK("bresp", 2'b10, cpu.last_bresp)
      cpu.wr(`PVIA_REG_CTRL, 32'h8);
      `CHK("bresp", 2'b00, cpu.last_bresp)
      repeat (2) @(posedge aclk);
      `CHK("cj", 1'b0, cj_comp_en)
      cpu.wr(`PVIA_REG_CTRL, 32'h0);
      repeat (2) @(posedge aclk);
      `CHK("cj", 1'b1, cj_comp_en)
      cj_short <= 1'b1;
      repeat (8) @(posedge aclk);
      `CHK("cj", 1'b0, cj_comp_en)
      cj_short <= 1'b0;
      repeat (8) @(posedge aclk);
      `CHK("cj", 1'b1, cj_comp_en)
      give_verdict;
   end
   initial begin
      #100000;
      fails++;
      give_verdict;
   end
endmodule
